//--- core/pvnr_regs.sv
// vector number setting registers for on-chip peripheral interrupts
//
// Local design decisions: the register offsets and the address-and-strobe port.
`timescale 1ns/10ps
`include "pvnr_consts.svh"
// How it works
// - five 16-bit registers, read and written over the register port
// - watchdog/bus-compare register bits 14:8 hold watchdog interval vector
// - watchdog/bus-compare register bits 6:0 hold refresh compare vector
// - serial receive register bits 14:8 hold receive-error vector
// - serial receive register bits 6:0 hold receive-data-full vector
// - serial transmit register bits 14:8 hold transmit-empty vector
// - serial transmit register bits 6:0 hold transmit-end vector
// - timer capture/compare register bits 14:8 hold input-capture vector
// - timer capture/compare register bits 6:0 hold output-compare vector
// - timer overflow register bits 14:8 hold overflow vector
// - each vector field is seven bits, any value 0 to 127
// - reset clears every register to zero
// - standby leaves every register unchanged
// - bits 15 and 7 are reserved, read zero, ignore writes
// - overflow register bits 7:0 and 15 read zero
// - table address is vector base plus four times the vector
module pvnr_regs
  import pvnr_pkg::*;
#(
  parameter int ADDR_W = `PVNR_ADDR_W,
  parameter int BASE_W = 32
)
(
  input  wire logic              clk_sys,
  input  wire logic              reset_n,
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [15:0]       reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [15:0]       reg_rdata,
  input  wire logic              standby,
  input  wire logic              irq_accept,
  input  wire logic [3:0]        irq_source,
  input  wire logic [BASE_W-1:0] vector_base_register,
  output logic      [6:0]        exc_vector,
  output logic                   exc_vector_valid,
  output logic      [BASE_W-1:0] exc_table_addr
);

  // elaboration guard: the offsets need four address bits, and a
  // seven-bit vector shifted by two needs nine bits of table address
  if (ADDR_W < `PVNR_ADDR_W || BASE_W < 9)
  begin : g_bad_params
    $error("pvnr_regs: address or base width too small");
  end

  // the seven-bit vector fields
  logic [6:0] wdog_interval_vector_ff;
  logic [6:0] buscmp_vector_ff;
  logic [6:0] serial_rxerr_vector_ff;
  logic [6:0] serial_rxfull_vector_ff;
  logic [6:0] serial_txempty_vector_ff;
  logic [6:0] serial_txend_vector_ff;
  logic [6:0] timer_capture_vector_ff;
  logic [6:0] timer_compare_vector_ff;
  logic [6:0] timer_overflow_vector_ff;
  logic [15:0] nxt_rdata;
  logic [6:0]  sel_vec;
  logic        sel_ok;
  logic [6:0]  hi_in;
  logic [6:0]  lo_in;
  // one write enable per register, decoded from the offset
  logic        wr_wdog;
  logic        wr_ser_rx;
  logic        wr_ser_tx;
  logic        wr_tmr_cc;
  logic        wr_tmr_ovf;

  // write-data field slices
  assign hi_in = reg_wdata[`PVNR_HI_MSB:`PVNR_HI_LSB];
  assign lo_in = reg_wdata[`PVNR_LO_MSB:`PVNR_LO_LSB];

  // write decode; a strobe to an unmapped offset enables nothing
  always_comb
  begin
    wr_wdog    = 1'b0;
    wr_ser_rx  = 1'b0;
    wr_ser_tx  = 1'b0;
    wr_tmr_cc  = 1'b0;
    wr_tmr_ovf = 1'b0;
    if (reg_wr)
    begin
      case (reg_addr)
        `PVNR_OFF_WDOG:    wr_wdog    = 1'b1;
        `PVNR_OFF_SER_RX:  wr_ser_rx  = 1'b1;
        `PVNR_OFF_SER_TX:  wr_ser_tx  = 1'b1;
        `PVNR_OFF_TMR_CC:  wr_tmr_cc  = 1'b1;
        `PVNR_OFF_TMR_OVF: wr_tmr_ovf = 1'b1;
        default:
        begin
          // unmapped writes are ignored
        end
      endcase
    end
  end

  // field registers; reserved write bits never reach them
  // watchdog interval field from bits 14:8
  pvnr_vec_field #(
    .W (`PVNR_VEC_W)
  ) wdog_interval_field_i (
    .clk_sys  (clk_sys),
    .reset_n  (reset_n),
    .wr_en    (wr_wdog),
    .wdata    (hi_in),
    .field_ff (wdog_interval_vector_ff)
  );

  // refresh compare field from bits 6:0
  pvnr_vec_field #(
    .W (`PVNR_VEC_W)
  ) buscmp_field_i (
    .clk_sys  (clk_sys),
    .reset_n  (reset_n),
    .wr_en    (wr_wdog),
    .wdata    (lo_in),
    .field_ff (buscmp_vector_ff)
  );

  pvnr_vec_field #(
    .W (`PVNR_VEC_W)
  ) serial_rxerr_field_i (
    .clk_sys  (clk_sys),
    .reset_n  (reset_n),
    .wr_en    (wr_ser_rx),
    .wdata    (hi_in),
    .field_ff (serial_rxerr_vector_ff)
  );

  pvnr_vec_field #(
    .W (`PVNR_VEC_W)
  ) serial_rxfull_field_i (
    .clk_sys  (clk_sys),
    .reset_n  (reset_n),
    .wr_en    (wr_ser_rx),
    .wdata    (lo_in),
    .field_ff (serial_rxfull_vector_ff)
  );

  pvnr_vec_field #(
    .W (`PVNR_VEC_W)
  ) serial_txempty_field_i (
    .clk_sys  (clk_sys),
    .reset_n  (reset_n),
    .wr_en    (wr_ser_tx),
    .wdata    (hi_in),
    .field_ff (serial_txempty_vector_ff)
  );

  pvnr_vec_field #(
    .W (`PVNR_VEC_W)
  ) serial_txend_field_i (
    .clk_sys  (clk_sys),
    .reset_n  (reset_n),
    .wr_en    (wr_ser_tx),
    .wdata    (lo_in),
    .field_ff (serial_txend_vector_ff)
  );

  pvnr_vec_field #(
    .W (`PVNR_VEC_W)
  ) timer_capture_field_i (
    .clk_sys  (clk_sys),
    .reset_n  (reset_n),
    .wr_en    (wr_tmr_cc),
    .wdata    (hi_in),
    .field_ff (timer_capture_vector_ff)
  );

  pvnr_vec_field #(
    .W (`PVNR_VEC_W)
  ) timer_compare_field_i (
    .clk_sys  (clk_sys),
    .reset_n  (reset_n),
    .wr_en    (wr_tmr_cc),
    .wdata    (lo_in),
    .field_ff (timer_compare_vector_ff)
  );

  // overflow field; the low write byte has no store
  pvnr_vec_field #(
    .W (`PVNR_VEC_W)
  ) timer_overflow_field_i (
    .clk_sys  (clk_sys),
    .reset_n  (reset_n),
    .wr_en    (wr_tmr_ovf),
    .wdata    (hi_in),
    .field_ff (timer_overflow_vector_ff)
  );

  // read mux; unmapped offsets read zero
  // reserved bits 15 and 7 read zero
  // overflow register low byte reads zero
  always_comb
  begin
    nxt_rdata = `PVNR_RESET_VAL;
    case (reg_addr)
      `PVNR_OFF_WDOG:
        nxt_rdata = {1'b0, wdog_interval_vector_ff, 1'b0, buscmp_vector_ff};
      `PVNR_OFF_SER_RX:
        nxt_rdata = {1'b0, serial_rxerr_vector_ff, 1'b0,
                     serial_rxfull_vector_ff};
      `PVNR_OFF_SER_TX:
        nxt_rdata = {1'b0, serial_txempty_vector_ff, 1'b0,
                     serial_txend_vector_ff};
      `PVNR_OFF_TMR_CC:
        nxt_rdata = {1'b0, timer_capture_vector_ff, 1'b0,
                     timer_compare_vector_ff};
      `PVNR_OFF_TMR_OVF:
        nxt_rdata = {1'b0, timer_overflow_vector_ff, 8'h00};
      default:
        nxt_rdata = `PVNR_RESET_VAL;
    endcase
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      reg_rdata <= `PVNR_RESET_VAL;
    else if (reg_rd)
      reg_rdata <= nxt_rdata;
    else
      reg_rdata <= `PVNR_RESET_VAL;
  end

  // source to vector lookup
  always_comb
  begin
    sel_ok  = 1'b1;
    sel_vec = `PVNR_VEC_ZERO;
    case (irq_source)
      PVNR_SRC_WDOG_INTERVAL: sel_vec = wdog_interval_vector_ff;
      PVNR_SRC_REFRESH_CMP:   sel_vec = buscmp_vector_ff;
      PVNR_SRC_SER_RXERR:     sel_vec = serial_rxerr_vector_ff;
      PVNR_SRC_SER_RXFULL:    sel_vec = serial_rxfull_vector_ff;
      PVNR_SRC_SER_TXEMPTY:   sel_vec = serial_txempty_vector_ff;
      PVNR_SRC_SER_TXEND:     sel_vec = serial_txend_vector_ff;
      PVNR_SRC_TMR_CAPTURE:   sel_vec = timer_capture_vector_ff;
      PVNR_SRC_TMR_COMPARE:   sel_vec = timer_compare_vector_ff;
      PVNR_SRC_TMR_OVERFLOW:  sel_vec = timer_overflow_vector_ff;
      default:                sel_ok  = 1'b0;
    endcase
  end

  // vector handed to the core one cycle after acceptance
  // present programmed vector on accept
  // table address = base + vector * 4
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      exc_vector       <= `PVNR_VEC_ZERO;
      exc_vector_valid <= 1'b0;
      exc_table_addr   <= '0;
    end
    else
    begin
      exc_vector_valid <= irq_accept && sel_ok;
      if (irq_accept && sel_ok)
      begin
        exc_vector     <= sel_vec;
        exc_table_addr <= vector_base_register
                          + (BASE_W'(sel_vec) << `PVNR_VEC_SCALE);
      end
    end
  end

endmodule // pvnr_regs

// one vector-number field: async clear, loaded on its write enable
module pvnr_vec_field
  import pvnr_pkg::*;
#(
  parameter int W = `PVNR_VEC_W
)
(
  input  wire logic         clk_sys,
  input  wire logic         reset_n,
  input  wire logic         wr_en,
  input  wire logic [W-1:0] wdata,
  output logic      [W-1:0] field_ff
);

  // a field of no bits cannot hold a vector
  if (W < 1)
  begin : g_bad_width
    $error("pvnr_vec_field: field width must be positive");
  end

  // standby is not a reset term, so contents persist
  // full field width stored, every code legal
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      field_ff <= '0;
    else if (wr_en)
      field_ff <= wdata;
  end

endmodule // pvnr_vec_field

//--- include/pvnr_consts.svh
// offsets, field positions and reset values of the vector number registers
`ifndef PVNR_CONSTS_SVH
`define PVNR_CONSTS_SVH

`define PVNR_ADDR_W        4
`define PVNR_OFF_WDOG      4'h0
`define PVNR_OFF_SER_RX    4'h2
`define PVNR_OFF_SER_TX    4'h4
`define PVNR_OFF_TMR_CC    4'h6
`define PVNR_OFF_TMR_OVF   4'h8
`define PVNR_HI_MSB        14
`define PVNR_HI_LSB        8
`define PVNR_LO_MSB        6
`define PVNR_LO_LSB        0
`define PVNR_VEC_W         7
`define PVNR_RESET_VAL     16'h0000
`define PVNR_VEC_ZERO      7'h00
`define PVNR_VEC_SCALE     2

`endif

//--- include/pvnr_pkg.sv
// types shared by the vector number register bank
package pvnr_pkg;
  // one code per peripheral interrupt source
  typedef enum logic [3:0] {
    PVNR_SRC_WDOG_INTERVAL = 4'h0,
    PVNR_SRC_REFRESH_CMP   = 4'h1,
    PVNR_SRC_SER_RXERR     = 4'h2,
    PVNR_SRC_SER_RXFULL    = 4'h3,
    PVNR_SRC_SER_TXEMPTY   = 4'h4,
    PVNR_SRC_SER_TXEND     = 4'h5,
    PVNR_SRC_TMR_CAPTURE   = 4'h6,
    PVNR_SRC_TMR_COMPARE   = 4'h7,
    PVNR_SRC_TMR_OVERFLOW  = 4'h8
  } pvnr_src_t;
endpackage

//--- dv/pvnr_regs_props.sv
// concurrent checks on the vector number register bank ports
`timescale 1ns/10ps
module pvnr_regs_props #(
  parameter int ADDR_W = 4,
  parameter int BASE_W = 32
) (
  input wire logic              clk_sys,
  input wire logic              reset_n,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [15:0]       reg_wdata,
  input wire logic              reg_wr,
  input wire logic              reg_rd,
  input wire logic [15:0]       reg_rdata,
  input wire logic              irq_accept,
  input wire logic [3:0]        irq_source,
  input wire logic [BASE_W-1:0] vector_base_register,
  input wire logic [6:0]        exc_vector,
  input wire logic              exc_vector_valid,
  input wire logic [BASE_W-1:0] exc_table_addr
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  a_rd_idle_zero: assert property (
    !$past(reg_rd) |-> reg_rdata == 16'h0000) else $error("stray read data");
  a_rsv_bits_zero: assert property (
    !reg_rdata[15] && !reg_rdata[7]) else $error("reserved bit set");
  a_ovf_low_zero: assert property (
    $past(reg_addr) == 4'h8 |-> reg_rdata[7:0] == 8'h00)
    else $error("overflow low byte set");
  a_wdog_readback: assert property (
    reg_wr && reg_addr == 4'h0 ##1 reg_rd && reg_addr == 4'h0
    |=> reg_rdata == ($past(reg_wdata, 2) & 16'h7F7F))
    else $error("watchdog register readback");
  a_valid_cause: assert property (
    exc_vector_valid |-> $past(irq_accept) && $past(irq_source) < 4'h9)
    else $error("valid without accept");
  a_accept_valid: assert property (
    irq_accept && irq_source < 4'h9 |=> exc_vector_valid)
    else $error("accept without valid");
  a_table_addr: assert property (
    exc_vector_valid |-> exc_table_addr ==
    $past(vector_base_register) + {exc_vector, 2'b00})
    else $error("table address wrong");
  a_vec_hold: assert property (
    !$past(irq_accept) |-> $stable(exc_vector) && $stable(exc_table_addr))
    else $error("vector moved without accept");
endmodule // pvnr_regs_props
bind pvnr_regs pvnr_regs_props #(.ADDR_W(ADDR_W), .BASE_W(BASE_W)) props_i (
  .clk_sys, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .irq_accept, .irq_source, .vector_base_register, .exc_vector,
  .exc_vector_valid, .exc_table_addr);

//--- dv/pvnr_core_model.sv
// processor core model that takes peripheral interrupt exceptions
`timescale 1ns/10ps
module pvnr_core_model (
  input  wire logic        clk_sys,
  output logic             irq_accept,
  output logic [3:0]       irq_source,
  input  wire logic [6:0]  exc_vector,
  input  wire logic        exc_vector_valid,
  input  wire logic [31:0] exc_table_addr
);
  initial irq_accept = 1'b0;
  initial irq_source = 4'hF;
  // one accept pulse; source scrambled after so a stale code is not reused
  task automatic take(input logic [3:0] s, output logic ok,
                      output logic [6:0] v, output logic [31:0] ta);
    irq_accept <= 1'b1;
    irq_source <= s;
    @(posedge clk_sys);
    irq_accept <= 1'b0;
    irq_source <= ~s;
    #1 ok = exc_vector_valid;
    v = exc_vector;
    ta = exc_table_addr;
    @(posedge clk_sys);
  endtask
endmodule // pvnr_core_model

//--- dv/tb.sv
// self-checking bench for the vector number register bank
`timescale 1ns/10ps
module tb;
  logic        clk_sys = 1'b0;
  logic        reset_n = 1'b0;
  logic [3:0]  reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic        standby = 1'b0;
  logic [31:0] vector_base_register = 32'h0;
  logic [15:0] reg_rdata;
  logic        irq_accept;
  logic [3:0]  irq_source;
  logic [6:0]  exc_vector;
  logic        exc_vector_valid;
  logic [31:0] exc_table_addr;
  logic [15:0] m [5];
  int          n_errors = 0;
  int          num_checks = 0;
  always #4 clk_sys = ~clk_sys;
  pvnr_regs pvnr_regs_i (.clk_sys, .reset_n, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .standby, .irq_accept, .irq_source,
    .vector_base_register, .exc_vector, .exc_vector_valid, .exc_table_addr);
  pvnr_core_model core_i (.clk_sys, .irq_accept, .irq_source, .exc_vector,
    .exc_vector_valid, .exc_table_addr);
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("wrong value %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(logic [3:0] a, logic [15:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  // read data stands only in the cycle after the strobe
  task automatic rd(logic [3:0] a, logic [15:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 chk("rdata", reg_rdata, e);
    @(posedge clk_sys);
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // hang guard
  initial
  begin
    repeat (5000) @(posedge clk_sys);
    n_errors++;
    wrap_up();
  end
  // main sequence: all-ones corners first, then random fields
  initial
  begin
    logic        ok;
    logic [6:0]  v;
    logic [31:0] ta;
    logic [15:0] d;
    int          k;
    void'($urandom(32'h1711));
    repeat (2) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(posedge clk_sys);
    for (int i = 0; i < 6; i++) rd(4'(2 * i), 16'h0000);
    for (int i = 0; i < 25; i++)
    begin
      k = i < 5 ? i : $urandom_range(4);
      d = i < 5 ? 16'hFFFF : 16'($urandom);
      m[k] = d & (k == 4 ? 16'h7F00 : 16'h7F7F);
      wr(4'(2 * k), m[k]);
      rd(4'(2 * k), m[k]);
    end
    wr(4'hC, 16'hFFFF);
    rd(4'hC, 16'h0000);
    // every source while in standby, then one unused code
    standby <= 1'b1;
    for (int s = 0; s < 10; s++)
    begin
      vector_base_register <= $urandom;
      @(posedge clk_sys);
      core_i.take(4'(s), ok, v, ta);
      d = m[s / 2] >> (s % 2 ? 0 : 8);
      chk("valid", ok, s < 9);
      if (s < 9)
        chk("vec", v, d[6:0]);
      if (s < 9) chk("addr", ta, vector_base_register + 4 * d[6:0]);
      if (s == 9) chk("held", v, 32'(m[4][14:8]));
    end
    for (int i = 0; i < 5; i++) rd(4'(2 * i), m[i]);
    reset_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(posedge clk_sys);
    for (int i = 0; i < 5; i++) rd(4'(2 * i), 16'h0000);
    wrap_up();
  end
endmodule // tb
